/* pmcm_partner.sv */
// Far-side model: wake pins, reset pin, RTC and sensor event sources.
// Assumes the bench gives requests on mclk; pulses are stretched here.
`timescale 1ns/1ps
`default_nettype none
module pmcm_partner #(
  parameter int GPIO_W = 8,
  parameter int EV_HOLD = 6
) (
  input wire logic mclk,
  input wire logic [GPIO_W-1:0] wake_req,
  input wire logic rtc_req,
  input wire logic sens_req,
  input wire logic rst_req,
  output logic [GPIO_W-1:0] wake_pin,
  output logic rtc_event,
  output logic sensor_event,
  output logic reset_pin_n
);
  int rtc_cnt = 0;
  int sens_cnt = 0;
  // Events held EV_HOLD cycles so the mclk synchroniser's agreement filter cannot miss them
  always @(posedge mclk) begin
    rtc_cnt <= rtc_req ? EV_HOLD : (rtc_cnt > 0 ? rtc_cnt - 1 : 0);
    sens_cnt <= sens_req ? EV_HOLD : (sens_cnt > 0 ? sens_cnt - 1 : 0);
    wake_pin <= wake_req;
    reset_pin_n <= !rst_req;
  end
  assign rtc_event = (rtc_cnt > 0);
  assign sensor_event = (sens_cnt > 0);
endmodule : pmcm_partner
`default_nettype wire

/* pmcm_pinlatch.sv */
// Holds the pin output levels while the latch request stands.
// Assumes the pin drive levels come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module pmcm_pinlatch #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [W-1:0] gpio_live,
  output logic [W-1:0] gpio_q
);
  // Follow live level, freeze while held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_q <= '0;
    end else if (!hold) begin
      gpio_q <= gpio_live;
    end
  end
endmodule : pmcm_pinlatch
`default_nettype wire

/* pmcm_pkg.sv */
// Constants for the power-mode and system-clock manager.
// Assumes a single 20 MHz clock mclk and an Avalon-MM register slave.
// Functional notes
// - Active mode runs the processor and clocks every software-enabled peripheral.
// - Idle gates processor and memory clocks; any interrupt returns to active.
// - Standby keeps only always-on domain; wakes on pin, RTC or sensor event.
// - Standby wake resumes processor in place; retained peripherals keep configuration.
// - Output levels stay latched at pre-entry values throughout standby.
// - Shutdown powers everything off; pins keep values from just before entry.
// - Level change on a shutdown wake pin wakes the device as a reset.
// - Reset cause register separates wake-pin, reset-pin and power-on resets.
// - Across shutdown only latched pins and nonvolatile memory survive.
// - High-speed clock runs in active and idle; off otherwise.
// - Medium-speed clock runs active, idle, standby; off in shutdown and reset.
// - Low-speed clock runs active, idle, standby; off in shutdown and reset.
// - State fully retained active/idle, partly in standby, none otherwise.
// - Reset pin wakes in every mode; RTC wake only active, idle, standby.
// - High-speed clock source selectable: RC oscillator, resonator or crystal.
// - Radio allowed only when high-speed clock comes from resonator or crystal.
// - Medium-speed clock always from its own RC oscillator, feeds sensor and power.
// - Low-speed source selectable among five options.
// - Low-speed clock drives RTC and radio timer resync around standby.
// - Low-speed clock may be driven out when from crystal or RC oscillator.
// - Sensor-controller peripherals are also controllable by the application processor.
// - Brownout on in active/idle, duty cycled standby, off shutdown; POR on through standby.
package pmcm_pkg;
  typedef enum logic [2:0] {
    PMCM_ACTIVE = 3'b000,
    PMCM_IDLE = 3'b001,
    PMCM_GATE = 3'b010,
    PMCM_LATCH = 3'b011,
    PMCM_STANDBY = 3'b100,
    PMCM_SHUTDOWN = 3'b101,
    PMCM_HELD = 3'b110
  } pmcm_mode_e;
  // Register word offsets (byte addresses)
  localparam logic [3:0] PMCM_OFS_MODE = 4'h0;
  localparam logic [3:0] PMCM_OFS_CLKSEL = 4'h4;
  localparam logic [3:0] PMCM_OFS_STATUS = 4'h8;
  localparam logic [3:0] PMCM_OFS_CAUSE = 4'hC;
  // Mode request codes
  localparam logic [1:0] PMCM_REQ_NONE = 2'h0;
  localparam logic [1:0] PMCM_REQ_IDLE = 2'h1;
  localparam logic [1:0] PMCM_REQ_STANDBY = 2'h2;
  localparam logic [1:0] PMCM_REQ_SHUTDOWN = 2'h3;
  // High-speed sources
  localparam logic [1:0] PMCM_HF_RC = 2'h0;
  localparam logic [1:0] PMCM_HF_RES = 2'h1;
  localparam logic [1:0] PMCM_HF_XTAL = 2'h2;
  // Low-speed sources
  localparam logic [2:0] PMCM_LF_RC = 3'h0;
  localparam logic [2:0] PMCM_LF_WATCH = 3'h1;
  localparam logic [2:0] PMCM_LF_RES = 3'h2;
  localparam logic [2:0] PMCM_LF_HFXTAL = 3'h3;
  localparam logic [2:0] PMCM_LF_PIN = 3'h4;
  // Clock select field positions
  localparam int PMCM_CS_HF_LSB = 0;
  localparam int PMCM_CS_LF_LSB = 4;
  localparam int PMCM_CS_LFOUT_BIT = 8;
  localparam int PMCM_CS_SCCPU_BIT = 9;
  // Reset cause codes
  localparam logic [1:0] PMCM_CAUSE_POR = 2'h0;
  localparam logic [1:0] PMCM_CAUSE_PIN = 2'h1;
  localparam logic [1:0] PMCM_CAUSE_WAKE = 2'h2;
  // Reset values
  localparam logic [1:0] PMCM_HF_RST = 2'h0;
  localparam logic [2:0] PMCM_LF_RST = 3'h0;
  // Gating settle time and duty-cycle period
  localparam int PMCM_CLK_MHZ = 20;
  localparam int PMCM_GATE_NS = 200;
  localparam int PMCM_GATE_CYC = (PMCM_GATE_NS * PMCM_CLK_MHZ + 999) / 1000;
  localparam int PMCM_DUTY_CYC = 16;
endpackage : pmcm_pkg

/* pmcm_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous input; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pmcm_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // Shift chain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Accept a bit once the last two stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule : pmcm_sync
`default_nettype wire

/* pmcm_tb_top.sv */
// Self-checking bench for the power-mode and clock manager.
// Assumes the partner model on the wake side and Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none
module pmcm_tb_top;
  import pmcm_pkg::*;
  logic mclk, rst_n, por_n, avs_read, avs_write, avs_waitrequest, irq_any;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] wake_req, wake_pin, shutdown_wake_en, gpio_live, gpio_out;
  logic rtc_req, sens_req, rst_req, rtc_event, sensor_event, reset_pin_n;
  logic cpu_clk_en, mem_clk_en, periph_clk_en, always_on_domain_pwr, sensor_pwr, retain_full;
  logic retain_partial, high_speed_system_clock_en, medium_speed_system_clock_en;
  logic low_speed_system_clock_en, low_speed_clock_out_en, radio_allowed, rtc_clk_en;
  logic radio_timer_resync, sensor_periph_cpu_ctl, brownout_detector_en, por_circuit_en, soft_reset;
  logic [1:0] high_speed_src;
  logic [2:0] low_speed_src;
  logic [11:0] pwr;
  int err_total = 0;
  int checks = 0;
  int rs_cnt = 0;
  int n0, nb;
  pmcm_top #(.GPIO_W(8)) dut (.*);
  pmcm_partner #(.GPIO_W(8)) far_side (.*);
  // Power and clock enables packed for one compare per mode
  assign pwr = {cpu_clk_en, mem_clk_en, periph_clk_en, always_on_domain_pwr, sensor_pwr, retain_full,
    retain_partial, high_speed_system_clock_en, medium_speed_system_clock_en, low_speed_system_clock_en,
    rtc_clk_en, por_circuit_en};
  // Clock source
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Resync pulse counter
  always @(posedge mclk) begin
    if (radio_timer_resync === 1'b1) rs_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // A write lands at this edge, so let it settle before outputs are compared
    if (wr) @(posedge mclk);
    if (n >= 20) chk(32'h1, 32'h0, "bus stall");
  endtask : bus
  // Reads the state field until it matches, bounded
  task automatic poll(input logic [2:0] m, input string what);
    int n;
    n = 0;
    do begin
      bus(1'b0, PMCM_OFS_MODE, 32'h0);
      n++;
    end while (rd[2:0] !== m && n < 40);
    chk({29'h0, rd[2:0]}, {29'h0, m}, what);
  endtask : poll
  task automatic pulse_ev(input int k);
    @(posedge mclk);
    if (k == 1) rtc_req <= 1'b1;
    else sens_req <= 1'b1;
    @(posedge mclk);
    rtc_req <= 1'b0;
    sens_req <= 1'b0;
  endtask : pulse_ev
  task automatic stop_test;
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    #(50 * 20000);
    err_total++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst_n, por_n, avs_read, avs_write, irq_any, rtc_req, sens_req, rst_req} = 8'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    {wake_req, shutdown_wake_en, gpio_live} = 24'h00_0000;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    bus(1'b0, PMCM_OFS_CAUSE, 32'h0);
    chk(rd, {30'h0, PMCM_CAUSE_POR}, "cause por");
    chk({20'h0, pwr}, 32'h0000_0FDF, "active pwr");
    chk({31'h0, brownout_detector_en}, 32'h1, "brownout active");
    bus(1'b0, 4'h6, 32'h0);
    chk(rd, 32'h0, "unmapped");
    // High-speed sources, code 3 refused
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, PMCM_OFS_CLKSEL, 32'h0000_0300 | i);
      chk({30'h0, high_speed_src}, (i == 3) ? 32'h2 : i, "hf src");
      chk({31'h0, radio_allowed}, (i == 0) ? 32'h0 : 32'h1, "radio");
      chk({31'h0, sensor_periph_cpu_ctl}, 32'h1, "sc ctl");
    end
    // Low-speed sources, code 5 refused
    for (int j = 0; j < 6; j++) begin
      bus(1'b1, PMCM_OFS_CLKSEL, 32'h0000_0100 | (j << 4));
      nb = (j == 5) ? 4 : j;
      chk({29'h0, low_speed_src}, nb, "lf src");
      chk({31'h0, low_speed_clock_out_en}, (nb != 2 && nb != 4), "lf out");
    end
    bus(1'b0, PMCM_OFS_CLKSEL, 32'h0);
    chk(rd, 32'h0000_0140, "clksel rd");
    bus(1'b1, PMCM_OFS_CLKSEL, 32'h0000_0312);
    bus(1'b0, PMCM_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0007, "status");
    // Idle, left by interrupt and by RTC
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, PMCM_OFS_MODE, {30'h0, PMCM_REQ_IDLE});
      poll(PMCM_IDLE, "idle");
      chk({20'h0, pwr}, 32'h0000_03DF, "idle pwr");
      if (k == 0) begin
        @(posedge mclk);
        irq_any <= 1'b1;
        @(posedge mclk);
        irq_any <= 1'b0;
      end else begin
        pulse_ev(1);
      end
      poll(PMCM_ACTIVE, "idle wake");
    end
    // Standby, woken by pin, RTC and sensor in turn
    for (int k = 0; k < 3; k++) begin
      gpio_live <= 8'hA5;
      n0 = rs_cnt;
      bus(1'b1, PMCM_OFS_MODE, {30'h0, PMCM_REQ_STANDBY});
      poll(PMCM_STANDBY, "standby");
      gpio_live <= 8'h5A;
      irq_any <= 1'b1;
      nb = 0;
      repeat (32) begin
        @(posedge mclk);
        if (brownout_detector_en === 1'b1) nb++;
      end
      irq_any <= 1'b0;
      chk(nb, 32'h2, "brownout duty");
      chk({24'h0, gpio_out}, 32'h0000_00A5, "gpio held");
      chk({20'h0, pwr}, 32'h0000_01AF, "standby pwr");
      chk(rs_cnt - n0, 32'h1, "resync in");
      poll(PMCM_STANDBY, "irq ignored");
      if (k == 0) wake_req <= 8'h01;
      else pulse_ev(k);
      poll(PMCM_ACTIVE, "standby wake");
      wake_req <= 8'h00;
      chk(rs_cnt - n0, 32'h2, "resync out");
      bus(1'b0, PMCM_OFS_CLKSEL, 32'h0);
      chk(rd, 32'h0000_0312, "clksel kept");
      repeat (8) @(posedge mclk);
      chk({24'h0, gpio_out}, 32'h0000_005A, "gpio live");
    end
    // Shutdown: RTC and a disabled pin ignored, enabled pin wakes
    shutdown_wake_en <= 8'h01;
    gpio_live <= 8'h3C;
    bus(1'b1, PMCM_OFS_MODE, {30'h0, PMCM_REQ_SHUTDOWN});
    poll(PMCM_SHUTDOWN, "shutdown");
    gpio_live <= 8'hC3;
    wake_req <= 8'h02;
    pulse_ev(1);
    repeat (12) @(posedge mclk);
    chk({24'h0, gpio_out}, 32'h0000_003C, "gpio sd");
    chk({20'h0, pwr}, 32'h0, "sd pwr");
    chk({30'h0, brownout_detector_en, soft_reset}, 32'h1, "sd brownout");
    poll(PMCM_SHUTDOWN, "sd stays");
    wake_req <= 8'h03;
    poll(PMCM_ACTIVE, "sd wake");
    wake_req <= 8'h00;
    bus(1'b0, PMCM_OFS_CAUSE, 32'h0);
    chk(rd, {30'h0, PMCM_CAUSE_WAKE}, "cause wake");
    bus(1'b0, PMCM_OFS_CLKSEL, 32'h0);
    chk(rd, 32'h0, "clksel lost");
    repeat (8) @(posedge mclk);
    // Reset pin with a sensor event at once in standby
    bus(1'b1, PMCM_OFS_MODE, {30'h0, PMCM_REQ_STANDBY});
    poll(PMCM_STANDBY, "standby 2");
    @(posedge mclk);
    rst_req <= 1'b1;
    sens_req <= 1'b1;
    @(posedge mclk);
    sens_req <= 1'b0;
    poll(PMCM_HELD, "held");
    chk({20'h0, pwr}, 32'h0, "held pwr");
    chk({31'h0, soft_reset}, 32'h1, "held rst");
    rst_req <= 1'b0;
    poll(PMCM_ACTIVE, "pin release");
    bus(1'b0, PMCM_OFS_CAUSE, 32'h0);
    chk(rd, {30'h0, PMCM_CAUSE_PIN}, "cause pin");
    // Power-on indication overrides the recorded pin cause
    @(posedge mclk);
    por_n <= 1'b0;
    @(posedge mclk);
    por_n <= 1'b1;
    bus(1'b0, PMCM_OFS_CAUSE, 32'h0);
    chk(rd, {30'h0, PMCM_CAUSE_POR}, "cause por again");
    stop_test();
  end
endmodule : pmcm_tb_top
`default_nettype wire

/* pmcm_top.sv */
// Power-mode sequencer and clock source selector with Avalon-MM registers.
// Assumes pins and wake events arrive asynchronously; gpio levels from mclk logic.
`timescale 1ns/1ps
`default_nettype none
module pmcm_top
  import pmcm_pkg::*;
#(
  parameter int GPIO_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic reset_pin_n,
  input wire logic [GPIO_W-1:0] wake_pin,
  input wire logic [GPIO_W-1:0] shutdown_wake_en,
  input wire logic rtc_event,
  input wire logic sensor_event,
  input wire logic irq_any,
  input wire logic [GPIO_W-1:0] gpio_live,
  output logic [GPIO_W-1:0] gpio_out,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic always_on_domain_pwr,
  output logic sensor_pwr,
  output logic retain_full,
  output logic retain_partial,
  output logic high_speed_system_clock_en,
  output logic [1:0] high_speed_src,
  output logic medium_speed_system_clock_en,
  output logic low_speed_system_clock_en,
  output logic [2:0] low_speed_src,
  output logic low_speed_clock_out_en,
  output logic radio_allowed,
  output logic rtc_clk_en,
  output logic radio_timer_resync,
  output logic sensor_periph_cpu_ctl,
  output logic brownout_detector_en,
  output logic por_circuit_en,
  output logic soft_reset
);
  pmcm_mode_e mode_r;
  pmcm_mode_e mode_nxt;
  pmcm_mode_e target_r;
  logic [1:0] hf_sel_r;
  logic [2:0] lf_sel_r;
  logic lfout_r;
  logic sccpu_r;
  logic [1:0] cause_r;
  logic [7:0] gate_cnt_r;
  logic [4:0] duty_cnt_r;
  logic [GPIO_W-1:0] shut_ref_r;
  logic rdone_r;
  logic pin_s;
  logic [GPIO_W-1:0] wake_s;
  logic rtc_s;
  logic sens_s;
  logic reset_held;
  logic pin_change;
  logic wake_stby;
  logic wr_mode;
  logic latch_hold;
  logic lf_out_ok;

  // Synchronise external inputs
  pmcm_sync #(.W(GPIO_W + 3)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({~reset_pin_n, wake_pin, rtc_event, sensor_event}),
    .dout({pin_s, wake_s, rtc_s, sens_s})
  );

  assign reset_held = pin_s;
  assign pin_change = |((wake_s ^ shut_ref_r) & shutdown_wake_en);
  assign wake_stby = (|wake_s) | rtc_s | sens_s;
  assign wr_mode = avs_write && (avs_address == PMCM_OFS_MODE) && avs_byteenable[0];
  assign latch_hold = (mode_r == PMCM_LATCH) || (mode_r == PMCM_STANDBY) || (mode_r == PMCM_SHUTDOWN);

  // Pin levels frozen from latch step through standby and shutdown
  pmcm_pinlatch #(.W(GPIO_W)) u_latch (
    .mclk(mclk),
    .rst_n(rst_n),
    .hold(latch_hold),
    .gpio_live(gpio_live),
    .gpio_q(gpio_out)
  );

  // Mode sequencer next state
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMCM_ACTIVE: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else if (wr_mode && avs_writedata[1:0] == PMCM_REQ_IDLE) begin
          mode_nxt = PMCM_IDLE;
        end else if (wr_mode && avs_writedata[1:0] != PMCM_REQ_NONE) begin
          mode_nxt = PMCM_GATE;
        end
      end
      PMCM_IDLE: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else if (irq_any || rtc_s) begin
          mode_nxt = PMCM_ACTIVE;
        end
      end
      PMCM_GATE: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else if (gate_cnt_r == 8'(PMCM_GATE_CYC)) begin
          mode_nxt = PMCM_LATCH;
        end
      end
      PMCM_LATCH: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else begin
          mode_nxt = target_r;
        end
      end
      PMCM_STANDBY: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else if (wake_stby) begin
          mode_nxt = PMCM_ACTIVE;
        end
      end
      PMCM_SHUTDOWN: begin
        if (reset_held) begin
          mode_nxt = PMCM_HELD;
        end else if (pin_change) begin
          mode_nxt = PMCM_ACTIVE;
        end
      end
      PMCM_HELD: begin
        if (!reset_held) begin
          mode_nxt = PMCM_ACTIVE;
        end
      end
      default: mode_nxt = PMCM_ACTIVE;
    endcase
  end

  // Mode register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= PMCM_ACTIVE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Target low-power mode captured on request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= PMCM_STANDBY;
    end else if (mode_r == PMCM_ACTIVE && wr_mode) begin
      target_r <= (avs_writedata[1:0] == PMCM_REQ_SHUTDOWN) ? PMCM_SHUTDOWN : PMCM_STANDBY;
    end
  end

  // Gating settle counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt_r <= '0;
    end else if (mode_r == PMCM_GATE) begin
      gate_cnt_r <= gate_cnt_r + 8'h01;
    end else begin
      gate_cnt_r <= '0;
    end
  end

  // Brownout duty-cycle counter for standby
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cnt_r <= '0;
    end else if (mode_r == PMCM_STANDBY) begin
      duty_cnt_r <= (duty_cnt_r == 5'(PMCM_DUTY_CYC - 1)) ? 5'h00 : duty_cnt_r + 5'h01;
    end else begin
      duty_cnt_r <= '0;
    end
  end

  // Wake-pin reference captured on shutdown entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shut_ref_r <= '0;
    end else if (mode_r == PMCM_LATCH) begin
      shut_ref_r <= wake_s;
    end
  end

  // Clock selection registers; cleared by shutdown or reset pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hf_sel_r <= PMCM_HF_RST;
      lf_sel_r <= PMCM_LF_RST;
      lfout_r <= 1'b0;
      sccpu_r <= 1'b0;
    end else if (mode_r == PMCM_SHUTDOWN || mode_r == PMCM_HELD) begin
      hf_sel_r <= PMCM_HF_RST;
      lf_sel_r <= PMCM_LF_RST;
      lfout_r <= 1'b0;
      sccpu_r <= 1'b0;
    end else if (avs_write && avs_address == PMCM_OFS_CLKSEL) begin
      if (avs_byteenable[0]) begin
        if (avs_writedata[PMCM_CS_HF_LSB +: 2] <= PMCM_HF_XTAL) begin
          hf_sel_r <= avs_writedata[PMCM_CS_HF_LSB +: 2];
        end
        if (avs_writedata[PMCM_CS_LF_LSB +: 3] <= PMCM_LF_PIN) begin
          lf_sel_r <= avs_writedata[PMCM_CS_LF_LSB +: 3];
        end
      end
      if (avs_byteenable[1]) begin
        lfout_r <= avs_writedata[PMCM_CS_LFOUT_BIT];
        sccpu_r <= avs_writedata[PMCM_CS_SCCPU_BIT];
      end
    end
  end

  // Reset cause: por, reset pin, or shutdown wake pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= PMCM_CAUSE_POR;
    end else if (!por_n) begin
      cause_r <= PMCM_CAUSE_POR;
    end else if (mode_r == PMCM_HELD) begin
      cause_r <= PMCM_CAUSE_PIN;
    end else if (mode_r == PMCM_SHUTDOWN && pin_change && !reset_held) begin
      cause_r <= PMCM_CAUSE_WAKE;
    end
  end

  // Output decode per mode
  assign cpu_clk_en = (mode_r == PMCM_ACTIVE);
  assign mem_clk_en = (mode_r == PMCM_ACTIVE);
  assign periph_clk_en = (mode_r == PMCM_ACTIVE) || (mode_r == PMCM_IDLE);
  assign always_on_domain_pwr = (mode_r != PMCM_SHUTDOWN) && (mode_r != PMCM_HELD);
  assign sensor_pwr = always_on_domain_pwr;
  assign retain_full = (mode_r == PMCM_ACTIVE) || (mode_r == PMCM_IDLE);
  assign retain_partial = (mode_r == PMCM_GATE) || (mode_r == PMCM_LATCH) || (mode_r == PMCM_STANDBY);
  assign high_speed_system_clock_en = retain_full;
  assign high_speed_src = hf_sel_r;
  assign medium_speed_system_clock_en = always_on_domain_pwr;
  assign low_speed_system_clock_en = always_on_domain_pwr;
  assign low_speed_src = lf_sel_r;
  assign lf_out_ok = (lf_sel_r == PMCM_LF_RC) || (lf_sel_r == PMCM_LF_WATCH) || (lf_sel_r == PMCM_LF_HFXTAL);
  assign low_speed_clock_out_en = lfout_r && lf_out_ok && low_speed_system_clock_en;
  assign radio_allowed = high_speed_system_clock_en && (hf_sel_r != PMCM_HF_RC);
  assign rtc_clk_en = low_speed_system_clock_en;
  assign radio_timer_resync = (mode_r == PMCM_LATCH) || (mode_r == PMCM_STANDBY && mode_nxt == PMCM_ACTIVE);
  assign sensor_periph_cpu_ctl = sccpu_r;
  assign brownout_detector_en = retain_full || (retain_partial && duty_cnt_r == 5'h00);
  assign por_circuit_en = always_on_domain_pwr;
  assign soft_reset = (mode_r == PMCM_HELD) || (mode_r == PMCM_SHUTDOWN);

  // Read answer takes one wait cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdone_r <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rdone_r <= avs_read && !rdone_r;
      avs_readdata <= '0;
      if (avs_read) begin
        unique case (avs_address)
          PMCM_OFS_MODE: avs_readdata <= {29'h0000_0000, mode_r};
          PMCM_OFS_CLKSEL: avs_readdata <= {22'h00_0000, sccpu_r, lfout_r, 1'b0, lf_sel_r, 2'b00, hf_sel_r};
          PMCM_OFS_STATUS: avs_readdata <= {29'h0000_0000, radio_allowed, retain_full, always_on_domain_pwr};
          PMCM_OFS_CAUSE: avs_readdata <= {30'h0000_0000, cause_r};
          default: avs_readdata <= '0;
        endcase
      end
    end
  end
  assign avs_waitrequest = avs_read && !rdone_r;

  // Checks
  a_idle_irq_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_IDLE && irq_any && !reset_held) |=> (mode_r == PMCM_ACTIVE && cpu_clk_en))
    else $error("idle did not wake on interrupt");
  a_stby_no_hf: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_STANDBY) |-> (!high_speed_system_clock_en && low_speed_system_clock_en && !periph_clk_en))
    else $error("standby clocks wrong");
  a_pins_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_STANDBY && $past(mode_r) == PMCM_STANDBY) |-> $stable(gpio_out))
    else $error("pins moved in standby");
  a_shut_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_SHUTDOWN) |-> (!always_on_domain_pwr && !brownout_detector_en && !medium_speed_system_clock_en))
    else $error("shutdown left power on");
  a_radio_src: assert property (@(posedge mclk) disable iff (!rst_n)
    radio_allowed |-> (hf_sel_r != PMCM_HF_RC))
    else $error("radio on rc clock");
  a_gate_first: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_ACTIVE ##1 mode_r == PMCM_GATE) |-> (mode_r == PMCM_GATE)[*5] ##1 mode_r == PMCM_LATCH)
    else $error("gating time wrong");
  a_held_prio: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_held && mode_r == PMCM_STANDBY) |=> (mode_r == PMCM_HELD))
    else $error("reset pin lost priority");
  a_wake_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_r == PMCM_SHUTDOWN && pin_change && !reset_held && por_n) |=> (cause_r == PMCM_CAUSE_WAKE))
    else $error("wake cause not recorded");
  a_lfout_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    low_speed_clock_out_en |-> (lf_sel_r != PMCM_LF_PIN && lf_sel_r != PMCM_LF_RES))
    else $error("lf out from bad source");
endmodule : pmcm_top
`default_nettype wire
